// [design/tfs_sequencer.sv]
/*
 * Frame sequencer top: frame memory, register port, sequencing, interrupts.
 * Assumes a host that holds bus_req until bus_ack and drops it between
 * accesses, and pins synchronous to clk_sys.
 */
`timescale 1ns/1ns
module tfs_sequencer import tfs_pkg::*; #(
    parameter int UNIT = UNIT_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register port
    input  wire logic        bus_req,
    input  wire logic        bus_we,
    input  wire logic [13:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    output logic             bus_ack,
    // Interrupt
    input  wire logic        irq_ack,
    output logic             irq_req,
    output logic      [2:0]  irq_level,
    // Front panel
    input  wire logic        ext_start,
    input  wire logic        ext_inhibit,
    input  wire logic        start_rise_sel,
    input  wire logic        inhibit_rise_sel,
    output logic             veto,
    output logic      [9:0]  frame_num,
    output logic      [7:0]  port_out
);
    tfs_state_type st_r;
    logic [15:0] mem_r [MEM_WORDS];
    logic [5:0]  ctrl_r;
    logic [3:0]  irq_st_r;
    logic [11:0] cycle_set_r;
    logic [11:0] cycle_cnt_r;
    logic [10:0] irq_id_r;
    logic [10:0] addr_cnt_r;
    logic [10:0] pre_idx_r;
    logic [12:0] pre_dur_r;
    logic [9:0]  pre_ctl_r;
    logic        cur_eoc_r;
    logic        pause_pend_r;
    logic        bus_busy_r;
    logic [1:0]  hold_cnt_r;
    logic [9:0]  frame_pend_r;
    logic [7:0]  port_pend_r;
    logic [15:0] bus_rdata_r;
    logic        bus_ack_r;
    logic        irq_req_r;
    logic        veto_r;
    logic [9:0]  frame_num_r;
    logic [7:0]  port_r;
    logic [15:0] rd_val;
    logic [15:0] ctl_word;
    logic        holdoff;
    logic        iack_take;
    logic        take;
    logic        rd_take;
    logic        wr_take;
    logic        cmd_start;
    logic        cmd_init;
    logic        start_edge;
    logic        inh_edge;
    logic        apply;
    logic        pause_now;
    logic        seq_end;
    logic        t_busy;
    logic        t_near;
    logic        t_done;
    logic [3:0]  ev_vec;
    logic [1:0]  st_code;

    function automatic logic hit(input logic [13:0] a, input logic [13:0] off);
        return a[13:1] == off[13:1];
    endfunction : hit

    assign holdoff   = (st_r == S_FETCH_DUR) || (st_r == S_FETCH_CTL) || (st_r == S_READY);
    assign iack_take = irq_ack && irq_req_r;
    assign take      = bus_req && !bus_busy_r && !holdoff && !iack_take;
    assign rd_take   = take && !bus_we;
    assign wr_take   = take && bus_we;
    assign cmd_init  = wr_take && hit(bus_addr, OFF_INIT);
    assign cmd_start = (wr_take && hit(bus_addr, OFF_START)) || start_edge;
    assign ctl_word  = mem_r[{addr_cnt_r, 1'b1}];
    assign seq_end   = (st_r == S_READY) && t_done && cur_eoc_r && (cycle_cnt_r == 12'h000);
    assign apply     = (st_r == S_READY) && (!t_busy || t_done) && !seq_end;
    assign pause_now = pre_ctl_r[CTL_PAUSE_BIT] || (pause_pend_r && !pre_idx_r[0]);
    assign st_code   = (st_r == S_IDLE) ? CODE_IDLE : (st_r == S_PAUSE) ? CODE_PAUSE : CODE_RUN;

    // Events are pulses, so enabling on a standing condition raises nothing
    assign ev_vec = {seq_end,
                     (st_r == S_READY) && t_done && cur_eoc_r,
                     apply && pause_now,
                     inh_edge} & ctrl_r[CR_IE_LSB +: 4];

    tfs_edge_detect u_start_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pin      (ext_start),
        .rise_sel (start_rise_sel),
        .enable   (ctrl_r[CR_EXT_START]),
        .pulse    (start_edge)
    );

    tfs_edge_detect u_inh_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pin      (ext_inhibit),
        .rise_sel (inhibit_rise_sel),
        .enable   (ctrl_r[CR_EXT_INH]),
        .pulse    (inh_edge)
    );

    tfs_frame_timer #(.UNIT(UNIT)) u_timer (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (apply),
        .rate     (pre_dur_r[DUR_RATE_LSB +: 3]),
        .count    (pre_dur_r[9:0]),
        .hold     (st_r == S_PAUSE),
        .stop     (cmd_init),
        .busy     (t_busy),
        .near_end (t_near),
        .done     (t_done)
    );

    // Frame memory, bus side write port
    always_ff @(posedge clk_sys) begin
        if (wr_take && !bus_addr[REG_SEL_BIT]) begin
            mem_r[bus_addr[12:1]] <= bus_wdata;
        end
    end

    always_comb begin
        rd_val = 16'h0000;
        if (!bus_addr[REG_SEL_BIT]) begin
            rd_val = mem_r[bus_addr[12:1]];
        end else if (hit(bus_addr, OFF_FRAME)) begin
            rd_val = {4'h0, addr_cnt_r, 1'b0};
        end else if (hit(bus_addr, OFF_CYCLE)) begin
            rd_val = {4'h0, cycle_cnt_r};
        end else if (hit(bus_addr, OFF_CTRL)) begin
            rd_val = {4'h0, irq_st_r, st_code, ctrl_r};
        end else if (hit(bus_addr, OFF_IRQID)) begin
            rd_val = {5'h00, irq_id_r};
        end
    end

    // Bus answers; an acknowledge cycle returns the vector
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_ack_r   <= 1'b0;
            bus_rdata_r <= 16'h0000;
            bus_busy_r  <= 1'b0;
        end else begin
            bus_ack_r  <= iack_take || take;
            bus_busy_r <= bus_req && (bus_busy_r || take);
            if (iack_take) begin
                bus_rdata_r <= {8'h00, irq_id_r[7:0]};
            end else if (take) begin
                bus_rdata_r <= bus_we ? 16'h0000 : rd_val;
            end
        end
    end

    // Writable registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r      <= CTRL_RESET;
            cycle_set_r <= CYCLE_RESET;
            irq_id_r    <= IRQID_RESET;
        end else if (cmd_init) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_take) begin
            if (hit(bus_addr, OFF_CTRL)) begin
                ctrl_r <= bus_wdata[5:0];
            end
            if (hit(bus_addr, OFF_CYCLE)) begin
                cycle_set_r <= bus_wdata[11:0];
            end
            if (hit(bus_addr, OFF_IRQID)) begin
                irq_id_r <= bus_wdata[10:0];
            end
        end
    end

    // Sequencing
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_init) begin
            st_r        <= S_IDLE;
            cycle_cnt_r <= 12'h000;
            addr_cnt_r  <= 11'h000;
            pre_idx_r   <= 11'h000;
            pre_dur_r   <= 13'h0000;
            pre_ctl_r   <= 10'h000;
            cur_eoc_r   <= 1'b0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (cmd_start) begin
                        cycle_cnt_r <= cycle_set_r;
                        addr_cnt_r  <= 11'h000;
                        st_r        <= S_FETCH_DUR;
                    end
                end
                S_FETCH_DUR: begin
                    pre_dur_r <= mem_r[{addr_cnt_r, 1'b0}][12:0];
                    pre_idx_r <= addr_cnt_r;
                    st_r      <= S_FETCH_CTL;
                end
                S_FETCH_CTL: begin
                    pre_ctl_r <= ctl_word[9:0];
                    if (ctl_word[CTL_EOC_BIT] && (cycle_cnt_r != 12'h000)) begin
                        addr_cnt_r <= 11'h000;
                    end else begin
                        addr_cnt_r <= addr_cnt_r + 11'h001;
                    end
                    st_r <= S_READY;
                end
                S_READY: begin
                    // Last frame may be dead or live; only its flag counts
                    if (t_done && cur_eoc_r && (cycle_cnt_r != 12'h000)) begin
                        cycle_cnt_r <= cycle_cnt_r - 12'h001;
                    end
                    if (seq_end) begin
                        st_r <= S_IDLE;
                    end else if (apply) begin
                        cur_eoc_r <= pre_ctl_r[CTL_EOC_BIT];
                        st_r      <= pause_now ? S_PAUSE : S_RUN;
                    end
                end
                S_RUN: begin
                    if (t_near) begin
                        st_r <= S_FETCH_DUR;
                    end
                end
                S_PAUSE: begin
                    if (cmd_start) begin
                        st_r <= S_RUN;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Pause request waits for the next dead frame; a new request wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_init || (st_r == S_IDLE)) begin
            pause_pend_r <= 1'b0;
        end else if ((wr_take && hit(bus_addr, OFF_PAUSE)) || inh_edge) begin
            pause_pend_r <= 1'b1;
        end else if (apply && !pre_idx_r[0]) begin
            pause_pend_r <= 1'b0;
        end
    end

    // Outputs: dead/live at once, frame number one hold later, port one hold later on a frame but cleared at once on init or run end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            veto_r       <= 1'b1;
            port_r       <= 8'h00;
            frame_num_r  <= 10'h000;
            frame_pend_r <= 10'h000;
            port_pend_r  <= 8'h00;
            hold_cnt_r   <= 2'h0;
        end else if (cmd_init || seq_end) begin
            veto_r       <= 1'b1;
            port_r       <= 8'h00;
            frame_pend_r <= 10'h000;
            port_pend_r  <= 8'h00;
            hold_cnt_r   <= 2'(INIT_HOLD_CYC);
        end else if (apply) begin
            veto_r       <= !pre_idx_r[0];
            frame_pend_r <= pre_idx_r[10:1];
            port_pend_r  <= pre_ctl_r[7:0];
            hold_cnt_r   <= 2'(INIT_HOLD_CYC);
        end else if (hold_cnt_r != 2'h0) begin
            hold_cnt_r <= hold_cnt_r - 2'h1;
            if (hold_cnt_r == 2'h1) begin
                frame_num_r <= frame_pend_r;
                port_r      <= port_pend_r;
            end
        end
    end

    // Interrupt causes and request; set wins over read and acknowledge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_st_r  <= 4'h0;
            irq_req_r <= 1'b0;
        end else begin
            if (cmd_init || (rd_take && hit(bus_addr, OFF_CTRL))) begin
                irq_st_r <= ev_vec;
            end else begin
                irq_st_r <= irq_st_r | ev_vec;
            end
            if (ev_vec != 4'h0) begin
                irq_req_r <= 1'b1;
            end else if (cmd_init || iack_take) begin
                irq_req_r <= 1'b0;
            end
        end
    end

    assign bus_rdata = bus_rdata_r;
    assign bus_ack   = bus_ack_r;
    assign irq_req   = irq_req_r;
    assign irq_level = irq_id_r[IRQ_LVL_LSB +: 3];
    assign veto      = veto_r;
    assign frame_num = frame_num_r;
    assign port_out  = port_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence fetch_seq;
        st_r == S_FETCH_DUR ##1 st_r == S_FETCH_CTL ##1 st_r == S_READY;
    endsequence
    sequence init_seq;
        cmd_init && !start_edge;
    endsequence

    status_clear_a: assert property (rd_take && hit(bus_addr, OFF_CTRL) && ev_vec == 4'h0
        |=> irq_st_r == 4'h0) else $error("status causes not cleared by read");
    iack_drop_a: assert property (iack_take && ev_vec == 4'h0 |=> !irq_req_r)
        else $error("request not withdrawn by acknowledge");
    irq_raise_a: assert property (ev_vec != 4'h0 && !cmd_init
        |=> irq_req_r && ((irq_st_r & $past(ev_vec)) == $past(ev_vec)))
        else $error("cause did not raise request and status");
    start_load_a: assert property (st_r == S_IDLE && cmd_start && !cmd_init
        |=> cycle_cnt_r == $past(cycle_set_r) && addr_cnt_r == 11'h000 ##0 fetch_seq)
        else $error("start did not load cycle count and fetch");
    prefetch_hold_a: assert property (st_r == S_RUN && t_near && !cmd_init
        |=> fetch_seq ##0 !bus_ack_r || $past(iack_take)) else $error("prefetch sequence broken");
    pause_timer_a: assert property (st_r == S_PAUSE |-> !t_done)
        else $error("timer ran while paused");
    frame_read_a: assert property (rd_take && hit(bus_addr, OFF_FRAME)
        |=> bus_ack_r && bus_rdata == {4'h0, $past(addr_cnt_r), 1'b0})
        else $error("frame position read wrong");
    run_end_a: assert property (seq_end && !cmd_init
        |=> st_r == S_IDLE && veto_r && port_r == 8'h00) else $error("run end not idle");
    pause_entry_a: assert property (apply && pause_now && !cmd_init
        |=> st_r == S_PAUSE && veto_r == !$past(pre_idx_r[0]))
        else $error("pause frame not applied");
    init_out_a: assert property (init_seq |=> veto_r && port_r == 8'h00
        ##[1:3] frame_num_r == 10'h000) else $error("initialise outputs wrong");
endmodule : tfs_sequencer

// [design/tfs_pkg.sv]
/*
 * Shared constants, state type and timebase helper for the frame sequencer.
 * Assumes a single 10 MHz system clock; times below are in ns or in clock cycles.
 */
package tfs_pkg;
    // Timing
    localparam int CLK_NS        = 100;
    localparam int UNIT_NS       = 10000;
    localparam int UNIT_CYC      = UNIT_NS / CLK_NS;
    localparam int PREFETCH_NS   = 4000;
    localparam int PREFETCH_CYC  = PREFETCH_NS / CLK_NS;
    localparam int INIT_HOLD_NS  = 100;
    localparam int INIT_HOLD_CYC = INIT_HOLD_NS / CLK_NS + 1;
    localparam int RATE_CODES    = 8;

    // Register map, byte offsets
    localparam logic [13:0] OFF_FRAME = 14'h2002;
    localparam logic [13:0] OFF_CYCLE = 14'h2006;
    localparam logic [13:0] OFF_CTRL  = 14'h200a;
    localparam logic [13:0] OFF_IRQID = 14'h200e;
    localparam logic [13:0] OFF_START = 14'h2012;
    localparam logic [13:0] OFF_PAUSE = 14'h2016;
    localparam logic [13:0] OFF_INIT  = 14'h201e;
    localparam int          REG_SEL_BIT = 13;
    localparam int          MEM_WORDS   = 4096;

    // Frame words
    localparam int DUR_RATE_LSB  = 10;
    localparam int CTL_EOC_BIT   = 9;
    localparam int CTL_PAUSE_BIT = 8;

    // Control and status fields
    localparam int CR_EXT_START = 0;
    localparam int CR_EXT_INH   = 1;
    localparam int CR_IE_LSB    = 2;
    localparam int ST_CODE_LSB  = 6;
    localparam int ST_IRQ_LSB   = 8;
    localparam int IRQ_LVL_LSB  = 8;
    localparam logic [1:0] CODE_IDLE  = 2'h0;
    localparam logic [1:0] CODE_RUN   = 2'h1;
    localparam logic [1:0] CODE_PAUSE = 2'h3;

    // Reset values
    localparam logic [5:0]  CTRL_RESET  = 6'h00;
    localparam logic [11:0] CYCLE_RESET = 12'h000;
    localparam logic [10:0] IRQID_RESET = 11'h000;

    typedef enum logic [2:0] {
        S_IDLE      = 3'h0,
        S_FETCH_DUR = 3'h1,
        S_FETCH_CTL = 3'h3,
        S_READY     = 3'h2,
        S_RUN       = 3'h6,
        S_PAUSE     = 3'h7
    } tfs_state_type;

    // Clock cycles per tick for a decade rate code
    function automatic logic [31:0] tfs_rate_cycles(input logic [2:0] code, input int unit);
        logic [31:0] p;
        p = 32'(unit);
        for (int i = 0; i < RATE_CODES - 1; i++) begin
            if (i < int'(code)) begin
                p = p * 32'h0000000a;
            end
        end
        return p;
    endfunction : tfs_rate_cycles
endpackage : tfs_pkg

// [design/tfs_edge_detect.sv]
/*
 * Active-edge detector for a front-panel input with selectable edge.
 * Assumes the pin is already synchronous to clk_sys.
 */
`timescale 1ns/1ns
module tfs_edge_detect (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Pin and selection
    input  wire logic pin,
    input  wire logic rise_sel,
    input  wire logic enable,
    // Event
    output logic      pulse
);
    logic prev_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= pin;
        end
    end

    assign pulse = enable && (pin != prev_r) && (pin == rise_sel);
endmodule : tfs_edge_detect

// [design/tfs_frame_timer.sv]
/*
 * Frame down-counter with decade prescaler from the system clock.
 * Assumes load comes only while idle or on the done cycle.
 */
`timescale 1ns/1ns
module tfs_frame_timer import tfs_pkg::*; #(
    parameter int UNIT = UNIT_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Frame load and control
    input  wire logic       load,
    input  wire logic [2:0] rate,
    input  wire logic [9:0] count,
    input  wire logic       hold,
    input  wire logic       stop,
    // Frame state
    output logic            busy,
    output logic            near_end,
    output logic            done
);
    logic [31:0] period_r;
    logic [31:0] sub_r;
    logic [9:0]  cnt_r;
    logic        busy_r;
    logic        tick;

    assign tick     = busy_r && !hold && (sub_r == 32'h0);
    assign done     = tick && (cnt_r == 10'h001);
    assign near_end = busy_r && (cnt_r == 10'h001) && (sub_r < 32'(PREFETCH_CYC));
    assign busy     = busy_r;

    // Reload on the done cycle itself, so frames follow with no gap
    always_ff @(posedge clk_sys) begin
        if (!rst_n || stop) begin
            busy_r   <= 1'b0;
            period_r <= 32'h0;
            sub_r    <= 32'h0;
            cnt_r    <= 10'h000;
        end else if (load) begin
            busy_r   <= 1'b1;
            period_r <= tfs_rate_cycles(rate, UNIT);
            sub_r    <= tfs_rate_cycles(rate, UNIT) - 32'h1;
            cnt_r    <= count;
        end else if (done) begin
            busy_r <= 1'b0;
        end else if (tick) begin
            sub_r <= period_r - 32'h1;
            cnt_r <= cnt_r - 10'h001;
        end else if (busy_r && !hold) begin
            sub_r <= sub_r - 32'h1;
        end
    end
endmodule : tfs_frame_timer

// [tb/tfs_host.sv]
/*
 * Host bus master model for the frame sequencer register port.
 * Assumes the sequencer answers each request with a one-cycle bus_ack.
 */
`timescale 1ns/1ns
module tfs_host (
    // Clock
    input  wire logic        clk_sys,
    // Register port
    output logic             bus_req,
    output logic             bus_we,
    output logic      [13:0] bus_addr,
    output logic      [15:0] bus_wdata,
    input  wire logic [15:0] bus_rdata,
    input  wire logic        bus_ack,
    // Interrupt
    output logic             irq_ack
);
    int n;
    initial begin
        bus_req   = 1'b0;
        bus_we    = 1'b0;
        bus_addr  = 14'h0000;
        bus_wdata = 16'h0000;
        irq_ack   = 1'b0;
    end
    // Sample at the falling edge, where the registered answer has settled
    task automatic wait_ack(output logic [15:0] q);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (bus_ack !== 1'b1 && n < 200);
        q = bus_rdata;
    endtask : wait_ack
    // Released lines show the inverse so stale values cannot pass
    task automatic xfer(input logic we, input logic [13:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(negedge clk_sys);
        bus_req   <= 1'b1;
        bus_we    <= we;
        bus_addr  <= a;
        bus_wdata <= d;
        wait_ack(q);
        @(negedge clk_sys);
        bus_req   <= 1'b0;
        bus_we    <= ~we;
        bus_addr  <= ~a;
        bus_wdata <= ~d;
    endtask : xfer
    task automatic iack(output logic [15:0] q);
        @(negedge clk_sys);
        irq_ack <= 1'b1;
        wait_ack(q);
        irq_ack <= 1'b0;
    endtask : iack
endmodule : tfs_host

// [tb/tfs_sequencer_tb.sv]
/*
 * Self-checking bench for the frame sequencer with a host model.
 * Assumes a shortened tick (UNIT 8) so a rate-1 tick is 80 cycles.
 */
`timescale 1ns/1ns
module tfs_sequencer_tb import tfs_pkg::*;;
    localparam logic [15:0] DUR = 16'h0401;
    logic        clk_sys, rst_n, bus_req, bus_we, bus_ack, irq_ack, irq_req, veto;
    logic        ext_start, ext_inhibit, start_rise_sel, inhibit_rise_sel;
    logic [13:0] bus_addr, ra;
    logic [15:0] bus_wdata, bus_rdata, q;
    logic [2:0]  irq_level;
    logic [9:0]  frame_num;
    logic [7:0]  port_out;
    logic [7:0]  pv [4];
    logic [31:0] seed = 32'd80;
    int          num_errors = 0, compares = 0, i;

    tfs_sequencer #(.UNIT(8)) tfs_sequencer_i (.clk_sys, .rst_n, .bus_req, .bus_we, .bus_addr,
        .bus_wdata, .bus_rdata, .bus_ack, .irq_ack, .irq_req, .irq_level, .ext_start,
        .ext_inhibit, .start_rise_sel, .inhibit_rise_sel, .veto, .frame_num, .port_out);
    tfs_host tfs_host_i (.clk_sys, .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_rdata,
        .bus_ack, .irq_ack);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        logic [15:0] r;
        tfs_host_i.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rdchk(input logic [13:0] a, input logic [15:0] exp);
        logic [15:0] r;
        tfs_host_i.xfer(1'b0, a, 16'h0000, r);
        chk(r, exp);
    endtask : rdchk
    task automatic outs(input logic v, input logic [9:0] f, input logic [7:0] p);
        chk({5'h00, veto, frame_num}, {5'h00, v, f});
        chk({8'h00, port_out}, {8'h00, p});
    endtask : outs
    task automatic irq_take(input logic [15:0] vec);
        int k;
        k = 0;
        while (irq_req !== 1'b1 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        tfs_host_i.iack(q);
        chk(q, vec);
        @(negedge clk_sys);
        chk({15'h0000, irq_req}, 16'h0000);
    endtask : irq_take
    task automatic prog(input logic [9:0] p, input logic [15:0] dc, input logic [15:0] lc);
        wr({1'b0, p, 3'h0}, DUR);
        wr({1'b0, p, 3'h2}, dc);
        wr({1'b0, p, 3'h4}, DUR);
        wr({1'b0, p, 3'h6}, lc);
    endtask : prog

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        {ext_start, ext_inhibit} = 2'b00;
        {start_rise_sel, inhibit_rise_sel} = 2'b11;
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        outs(1'b1, 10'h000, 8'h00);
        rdchk(OFF_CTRL, 16'h0000);
        rdchk(14'h201a, 16'h0000);
        for (i = 0; i < 4; i++) begin
            q = rnd();
            ra = 14'(rnd()) & 14'h1ffe;
            wr(ra, q);
            rdchk(ra, q);
            pv[i] = 8'(rnd());
        end
        $display("test memory done");
        prog(10'h000, {8'h00, pv[0]}, {8'h00, pv[1]});
        prog(10'h001, {8'h00, pv[2]}, {8'h02, pv[3]});
        wr(OFF_CYCLE, 16'h0001);
        wr(OFF_IRQID, 16'h0380);
        chk({13'h0000, irq_level}, 16'h0003);
        wr(OFF_CTRL, 16'h0030);
        wr(OFF_START, rnd());
        rdchk(OFF_FRAME, 16'h0002);
        rdchk(OFF_CYCLE, 16'h0001);
        rdchk(OFF_CTRL, 16'h0070);
        outs(1'b1, 10'h000, pv[0]);
        irq_take(16'h0080);
        rdchk(OFF_CTRL, 16'h0470);
        rdchk(OFF_CTRL, 16'h0070);
        rdchk(OFF_CYCLE, 16'h0000);
        irq_take(16'h0080);
        rdchk(OFF_CTRL, 16'h0c30);
        outs(1'b1, 10'h000, 8'h00);
        $display("test cycles done");
        wr(14'h0002, {8'h01, pv[0]});
        wr(OFF_CYCLE, 16'h0000);
        wr(OFF_CTRL, 16'h0008);
        wr(OFF_START, rnd());
        irq_take(16'h0080);
        outs(1'b1, 10'h000, pv[0]);
        repeat (200) @(negedge clk_sys);
        rdchk(OFF_CTRL, 16'h02c8);
        wr(OFF_START, rnd());
        wr(OFF_PAUSE, rnd());
        irq_take(16'h0080);
        outs(1'b1, 10'h001, pv[2]);
        rdchk(OFF_FRAME, 16'h0006);
        wr(OFF_INIT, rnd());
        repeat (3) @(negedge clk_sys);
        outs(1'b1, 10'h000, 8'h00);
        rdchk(OFF_CTRL, 16'h0000);
        $display("test pause done");
        wr(14'h0002, {8'h00, pv[0]});
        wr(OFF_CTRL, 16'h0007);
        @(negedge clk_sys) ext_start = 1'b1;
        repeat (2) @(negedge clk_sys);
        ext_start = 1'b0;
        rdchk(OFF_CTRL, 16'h0047);
        ext_inhibit = 1'b1;
        irq_take(16'h0080);
        rdchk(OFF_CTRL, 16'h0147);
        ext_inhibit = 1'b0;
        repeat (400) @(negedge clk_sys);
        wr(OFF_CTRL, 16'h000f);
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, irq_req}, 16'h0000);
        rdchk(OFF_CTRL, 16'h00cf);
        outs(1'b1, 10'h001, pv[2]);
        $display("test inputs done");
        complete_run();
    end
endmodule : tfs_sequencer_tb
